// >>> common/emr_cfg.svh
`ifndef EMR_CFG_SVH
`define EMR_CFG_SVH

// opcode bit positions of the extended register
`define EMR_DLL_BIT        0
`define EMR_DRIVE_BIT      1
`define EMR_RTT_LO_BIT     2
`define EMR_AL_LSB         3
`define EMR_AL_MSB         5
`define EMR_RTT_HI_BIT     6
`define EMR_DQSN_DIS_BIT   10
`define EMR_RDQS_EN_BIT    11
`define EMR_OUT_DIS_BIT    12

// widths
`define EMR_OPCODE_W       13
`define EMR_LAT_W          4

// register select values carried on the bank address
`define EMR_SEL_BASE       2'h0
`define EMR_SEL_EXT        2'h1
`define EMR_SEL_SECOND     2'h2
`define EMR_SEL_THIRD      2'h3

// reset values
`define EMR_EXT_RESET      13'h0000
`define EMR_SECOND_RESET   13'h0000
`define EMR_DLL_EN_RESET   1'b1

// termination select codes {high, low}
`define EMR_RTT_OFF        2'h0
`define EMR_RTT_75         2'h1
`define EMR_RTT_150        2'h2

// largest legal additive latency
`define EMR_AL_MAX         3'h4
`define EMR_AL_ZERO        3'h0

// write latency is read latency less this
`define EMR_WL_OFFSET      4'h1
`define EMR_LAT_ZERO       4'h0

`endif

// >>> common/emr_pkg.sv
package emr_pkg;

   // power state seen from the command pins
   typedef enum logic [1:0] {
      pwr_active,
      pwr_power_down,
      pwr_self_refresh
   } power_state_e;

   // command pins sampled on the rising clock edge
   typedef struct packed {
      logic        cke;
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [1:0]  ba;
      logic [12:0] addr;
   } cmd_pins_s;

   // strobe and data enables produced by the read path
   typedef struct packed {
      logic dq_oe;
      logic dqs;
      logic dqs_oe;
      logic reading;
   } read_path_s;

   // gated pad controls
   typedef struct packed {
      logic dq_oe;
      logic dqs_oe;
      logic dqs_n;
      logic dqs_n_oe;
      logic rdqs;
      logic rdqs_oe;
      logic rdqs_n;
      logic rdqs_n_oe;
   } pad_ctrl_s;

endpackage

// >>> src/sdram_extended_mode_config.sv
`timescale 1ns/10ps
`include "emr_cfg.svh"
// What this block does
// - DLL enable follows loaded DLL control bit
// - self refresh disables DLL, exit re-enables, resets
// - drive strength bit selects full or reduced
// - complement disable bit kills DQS# pin
// - RDQS# only with RDQS on, DQS# on
// - x8 RDQS copies DQS on reads only
// - output disable bit turns off data outputs
// - termination bits select 75 or 150 ohm
// - ODT pin switches termination in allowed states
// - ODT pin ignored during self refresh
// - additive latency field selects zero to four
// - column commands delayed by additive latency
// - read latency equals additive plus CAS
// - write latency is read latency minus one
// - second extended register stored, all reserved
// - bank address selects target register
// - load decoded from all-low strobes, CKE high
module sdram_extended_mode_config
   import emr_pkg::*;
#(
   parameter bit          IS_X8      = 1'b1,
   parameter int unsigned HIST_DEPTH = 16
) (
   // clock and reset
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_arst_n,
   // command bus
   input  wire cmd_pins_s                i_cmd,
   input  wire logic [2:0]               i_cas_latency,
   input  wire logic                     i_odt,
   // read path strobes before gating
   input  wire read_path_s               i_rd,
   // configuration and derived controls
   output logic                          o_dll_enable,
   output logic                          o_dll_reset,
   output logic                          o_drive_reduced,
   output logic [1:0]                    o_rtt_sel,
   output logic                          o_rtt_on,
   output logic [2:0]                    o_additive_latency,
   output logic [`EMR_LAT_W-1:0]         o_read_latency,
   output logic [`EMR_LAT_W-1:0]         o_write_latency,
   output logic [`EMR_OPCODE_W-1:0]      o_second_ext,
   output power_state_e                  o_power_state,
   // internally issued column commands and data timing
   output logic                          o_int_read,
   output logic                          o_int_write,
   output logic                          o_read_data_due,
   output logic                          o_write_data_due,
   // gated pad controls
   output pad_ctrl_s                     o_pad
);

   typedef struct packed {
      logic [`EMR_OPCODE_W-1:0] ext;
      logic [`EMR_OPCODE_W-1:0] second;
      logic                     cke_prev;
      power_state_e             pwr;
      logic                     dll_reset;
      logic                     dll_en;
      logic [1:0]               rtt_sel;
      logic                     rtt_on;
      logic [HIST_DEPTH-1:0]    rd_hist;
      logic [HIST_DEPTH-1:0]    wr_hist;
      logic                     int_read;
      logic                     int_write;
      logic                     rd_due;
      logic                     wr_due;
      logic [`EMR_LAT_W-1:0]    rl;
      logic [`EMR_LAT_W-1:0]    wl;
      pad_ctrl_s                pad;
   } state_s;

   state_s s_q;
   state_s s_d;

   // command decode, valid only with CKE high on both edges
   logic cmd_valid;
   logic is_load;
   logic is_read;
   logic is_write;
   logic is_sr_entry;
   logic cke_fall;
   logic cke_rise;

   assign cmd_valid   = s_q.cke_prev & i_cmd.cke & ~i_cmd.cs_n;
   assign is_load     = cmd_valid & ~i_cmd.ras_n & ~i_cmd.cas_n
                        & ~i_cmd.we_n;
   assign is_read     = cmd_valid & i_cmd.ras_n & ~i_cmd.cas_n
                        & i_cmd.we_n;
   assign is_write    = cmd_valid & i_cmd.ras_n & ~i_cmd.cas_n
                        & ~i_cmd.we_n;
   assign cke_fall    = s_q.cke_prev & ~i_cmd.cke;
   assign cke_rise    = ~s_q.cke_prev & i_cmd.cke;
   assign is_sr_entry = cke_fall & ~i_cmd.cs_n & ~i_cmd.ras_n
                        & ~i_cmd.cas_n & i_cmd.we_n;

   // effective fields of the stored extended register
   logic [2:0]            al_eff;
   logic [1:0]            rtt_code;
   logic                  rtt_enabled;
   logic [`EMR_LAT_W-1:0] rl_sum;
   logic [`EMR_LAT_W-1:0] wl_sum;

   // reserved latency codes fall back to zero
   assign al_eff = (s_q.ext[`EMR_AL_MSB:`EMR_AL_LSB] > `EMR_AL_MAX)
                 ? `EMR_AL_ZERO
                 : s_q.ext[`EMR_AL_MSB:`EMR_AL_LSB];
   assign rtt_code    = {s_q.ext[`EMR_RTT_HI_BIT],
                         s_q.ext[`EMR_RTT_LO_BIT]};
   // reserved combination leaves termination off
   assign rtt_enabled = (rtt_code == `EMR_RTT_75)
                      | (rtt_code == `EMR_RTT_150);
   assign rl_sum = {1'b0, al_eff} + {1'b0, i_cas_latency};
   assign wl_sum = (rl_sum == `EMR_LAT_ZERO) ? `EMR_LAT_ZERO
                 : rl_sum - `EMR_WL_OFFSET;

   // pick a command delayed by n clocks from the history
   function automatic logic tap(input logic                  now,
                                input logic [HIST_DEPTH-1:0] h,
                                input logic [`EMR_LAT_W-1:0] n);
      logic r;
      if (n == `EMR_LAT_ZERO) begin
         r = now;
      end else if (32'(n) > HIST_DEPTH) begin
         r = 1'b0;
      end else begin
         r = h[n - `EMR_WL_OFFSET];
      end
      return r;
   endfunction

   // next state
   always_comb begin
      logic       rd_ok;
      logic       dqsn_on;
      logic       rdqs_on;
      logic       outs_on;
      logic [1:0] nxt_rtt;
      rd_ok         = 1'b0;
      dqsn_on       = 1'b0;
      rdqs_on       = 1'b0;
      outs_on       = 1'b0;
      nxt_rtt       = `EMR_RTT_OFF;
      s_d           = s_q;
      s_d.cke_prev  = i_cmd.cke;
      s_d.dll_reset = 1'b0;

      // mode load into the register the bank address selects
      if (is_load) begin
         case (i_cmd.ba)
            `EMR_SEL_EXT: begin
               s_d.ext = i_cmd.addr;
            end
            `EMR_SEL_SECOND: begin
               s_d.second = i_cmd.addr;
            end
            default: begin
               s_d.ext = s_q.ext;
            end
         endcase
      end

      // power state tracking from CKE and the command pins
      case (s_q.pwr)
         pwr_active: begin
            if (is_sr_entry) begin
               s_d.pwr = pwr_self_refresh;
            end else if (cke_fall) begin
               s_d.pwr = pwr_power_down;
            end
         end
         pwr_power_down: begin
            if (cke_rise) begin
               s_d.pwr = pwr_active;
            end
         end
         pwr_self_refresh: begin
            if (cke_rise) begin
               s_d.pwr       = pwr_active;
               s_d.dll_reset = 1'b1;
            end
         end
         default: begin
            s_d.pwr = pwr_active;
         end
      endcase

      // decoded settings registered from the next state, no extra delay
      s_d.dll_en  = ~s_d.ext[`EMR_DLL_BIT]
                  & (s_d.pwr != pwr_self_refresh);
      nxt_rtt     = {s_d.ext[`EMR_RTT_HI_BIT], s_d.ext[`EMR_RTT_LO_BIT]};
      s_d.rtt_sel = ((nxt_rtt == `EMR_RTT_75) | (nxt_rtt == `EMR_RTT_150))
                  ? nxt_rtt : `EMR_RTT_OFF;

      // termination follows the pin except in self refresh
      s_d.rtt_on = rtt_enabled & i_odt
                 & (s_q.pwr != pwr_self_refresh)
                 & ~is_sr_entry;

      // posted column commands and data timing
      s_d.rd_hist   = {s_q.rd_hist[HIST_DEPTH-2:0], is_read};
      s_d.wr_hist   = {s_q.wr_hist[HIST_DEPTH-2:0], is_write};
      s_d.int_read  = tap(is_read, s_q.rd_hist,
                          {1'b0, al_eff});
      s_d.int_write = tap(is_write, s_q.wr_hist,
                          {1'b0, al_eff});
      s_d.rd_due    = tap(is_read, s_q.rd_hist, rl_sum);
      s_d.wr_due    = tap(is_write, s_q.wr_hist, wl_sum);
      s_d.rl        = rl_sum;
      s_d.wl        = wl_sum;

      // pad gating
      outs_on = ~s_q.ext[`EMR_OUT_DIS_BIT];
      dqsn_on = ~s_q.ext[`EMR_DQSN_DIS_BIT];
      rdqs_on = IS_X8 & s_q.ext[`EMR_RDQS_EN_BIT];
      rd_ok   = rdqs_on & i_rd.reading;
      s_d.pad.dq_oe     = outs_on & i_rd.dq_oe;
      s_d.pad.dqs_oe    = outs_on & i_rd.dqs_oe;
      s_d.pad.dqs_n     = ~i_rd.dqs;
      s_d.pad.dqs_n_oe  = outs_on & dqsn_on & i_rd.dqs_oe;
      s_d.pad.rdqs      = i_rd.dqs;
      s_d.pad.rdqs_oe   = outs_on & rd_ok & i_rd.dqs_oe;
      s_d.pad.rdqs_n    = ~i_rd.dqs;
      s_d.pad.rdqs_n_oe = outs_on & rd_ok & dqsn_on
                          & i_rd.dqs_oe;
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q        <= '0;
         s_q.ext    <= `EMR_EXT_RESET;
         s_q.second <= `EMR_SECOND_RESET;
         s_q.pwr    <= pwr_active;
         s_q.dll_en <= `EMR_DLL_EN_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign o_dll_enable       = s_q.dll_en;
   assign o_dll_reset        = s_q.dll_reset;
   assign o_drive_reduced    = s_q.ext[`EMR_DRIVE_BIT];
   assign o_rtt_sel          = s_q.rtt_sel;
   assign o_rtt_on           = s_q.rtt_on;
   assign o_additive_latency = s_q.ext[`EMR_AL_MSB:`EMR_AL_LSB];
   assign o_read_latency     = s_q.rl;
   assign o_write_latency    = s_q.wl;
   assign o_second_ext       = s_q.second;
   assign o_power_state      = s_q.pwr;
   assign o_int_read         = s_q.int_read;
   assign o_int_write        = s_q.int_write;
   assign o_read_data_due    = s_q.rd_due;
   assign o_write_data_due   = s_q.wr_due;
   assign o_pad              = s_q.pad;

endmodule

// >>> tb/emr_chk_assertions.sv
`timescale 1ns/10ps
`include "emr_cfg.svh"
module emr_chk
   import emr_pkg::*;
(
   // watched ports
   input wire logic                  i_ref_clk,
   input wire logic                  i_arst_n,
   input wire logic [2:0]            i_cas_latency,
   input wire logic                  i_odt,
   input wire read_path_s            i_rd,
   input wire logic                  o_dll_enable,
   input wire logic                  o_dll_reset,
   input wire logic [1:0]            o_rtt_sel,
   input wire logic                  o_rtt_on,
   input wire logic [2:0]            o_additive_latency,
   input wire logic [`EMR_LAT_W-1:0] o_read_latency,
   input wire logic [`EMR_LAT_W-1:0] o_write_latency,
   input wire power_state_e          o_power_state,
   input wire pad_ctrl_s             o_pad
);
   logic       up_q;
   logic [3:0] rl;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   // reserved additive codes count as zero
   assign rl = {1'b0, o_additive_latency > 3'h4 ? 3'h0 : o_additive_latency}
      + {1'b0, i_cas_latency};
   // first settled cycle after reset
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
      if (!i_arst_n)
         up_q <= 1'b0;
      else
         up_q <= 1'b1;
   // dll and termination are off in self refresh
   property p_dll_sr;
      o_power_state == pwr_self_refresh |-> !o_dll_enable && !o_rtt_on;
   endproperty
   a_dll_sr: assert property (p_dll_sr)
      else $error("dll or odt on in self refresh");
   // one reset pulse, only right after leaving self refresh
   property p_dll_rst;
      o_dll_reset |-> o_dll_enable && $past(o_power_state) == pwr_self_refresh
         ##1 !o_dll_reset;
   endproperty
   a_dll_rst: assert property (p_dll_rst)
      else $error("bad dll reset");
   property p_rl;
      up_q |-> o_read_latency == $past(rl);
   endproperty
   a_rl: assert property (p_rl)
      else $error("read latency");
   property p_wl;
      up_q && $past(rl) != 4'h0 |-> o_write_latency == $past(rl) - 4'h1;
   endproperty
   a_wl: assert property (p_wl)
      else $error("write latency");
   // pin switches termination in active and power-down states
   property p_odt_on;
      $past(i_odt) && $past(o_rtt_sel) != 2'h0
         && $past(o_power_state) != pwr_self_refresh
         && o_power_state != pwr_self_refresh |-> o_rtt_on;
   endproperty
   a_odt_on: assert property (p_odt_on)
      else $error("odt not on");
   property p_odt_off;
      !$past(i_odt) |-> !o_rtt_on;
   endproperty
   a_odt_off: assert property (p_odt_off)
      else $error("odt not off");
   property p_dqsn;
      o_pad.dqs_n_oe |-> $past(i_rd.dqs_oe)
         && o_pad.dqs_n == !$past(i_rd.dqs);
   endproperty
   a_dqsn: assert property (p_dqsn)
      else $error("dqs complement");
   property p_rdqsn;
      o_pad.rdqs_n_oe |-> o_pad.rdqs_oe && o_pad.dqs_n_oe;
   endproperty
   a_rdqsn: assert property (p_rdqsn)
      else $error("rdqs complement");
   property p_rdqs;
      o_pad.rdqs_oe |-> $past(i_rd.reading)
         && o_pad.rdqs == $past(i_rd.dqs);
   endproperty
   a_rdqs: assert property (p_rdqs)
      else $error("rdqs copy");
   c_dll: cover property (o_dll_reset);
   c_odt: cover property (o_rtt_on);
   c_rdqs: cover property (o_pad.rdqs_n_oe);
   c_pd: cover property (o_power_state == pwr_power_down && o_rtt_on);
endmodule
bind sdram_extended_mode_config emr_chk emr_chk_inst (.i_ref_clk, .i_arst_n,
   .i_cas_latency, .i_odt, .i_rd, .o_dll_enable, .o_dll_reset, .o_rtt_sel,
   .o_rtt_on, .o_additive_latency, .o_read_latency, .o_write_latency,
   .o_power_state, .o_pad);

// >>> tb/emr_ctl.sv
`timescale 1ns/10ps
module emr_ctl
   import emr_pkg::*;
#(
   parameter int MRD = 2
) (
   // clock
   input  wire logic i_ref_clk,
   // command bus toward the device
   output cmd_pins_s o_cmd
);
   // idle bus with termination never enabled before a load
   initial o_cmd = {1'b1, 1'b0, 3'h7, 2'h0, 13'h0000};
   // one command cycle, then nop with inverted address
   task automatic issue(input logic [2:0] rcw, input logic cke,
                        input logic [1:0] ba, input logic [12:0] a);
      @(posedge i_ref_clk);
      o_cmd <= {cke, 1'b0, rcw, ba, a};
      @(posedge i_ref_clk);
      o_cmd <= {cke, 1'b0, 3'h7, ba, ~a};
   endtask
   // register load with calibration bits at default
   task automatic load(input logic [1:0] ba, input logic [12:0] a);
      issue(3'h0, 1'b1, ba, a & 13'h1C7F);
      repeat (MRD) @(posedge i_ref_clk);
      if (ba == 2'h1 && !a[0]) begin
         issue(3'h0, 1'b1, 2'h0, 13'h0100);
         repeat (200) @(posedge i_ref_clk);
      end
   endtask
   // self refresh entry or exit, settle wait on exit
   task automatic selfref(input logic enter);
      issue(enter ? 3'h1 : 3'h7, !enter, 2'h0, 13'h0000);
      if (!enter)
         repeat (200) @(posedge i_ref_clk);
   endtask
endmodule

// >>> tb/sdram_extended_mode_config_tb_top.sv
`timescale 1ns/10ps
`include "emr_cfg.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("Error %0t got %h exp %h", $time, a, e); end end
module sdram_extended_mode_config_tb_top;
   import emr_pkg::*;
   logic         i_ref_clk, i_arst_n, i_odt, o_dll_enable, o_dll_reset;
   logic         o_drive_reduced, o_rtt_on, o_int_read, o_int_write;
   logic         o_read_data_due, o_write_data_due;
   logic [1:0]   o_rtt_sel;
   logic [2:0]   i_cas_latency, o_additive_latency;
   logic [3:0]   o_read_latency, o_write_latency;
   logic [12:0]  o_second_ext;
   cmd_pins_s    i_cmd;
   read_path_s   i_rd;
   pad_ctrl_s    o_pad;
   power_state_e o_power_state;
   int           mismatches, n_checks, n_rst, k[2];
   emr_ctl emr_ctl_inst (.i_ref_clk, .o_cmd(i_cmd));
   sdram_extended_mode_config sdram_extended_mode_config_inst (.i_ref_clk,
      .i_arst_n, .i_cmd, .i_cas_latency, .i_odt, .i_rd, .o_dll_enable,
      .o_dll_reset, .o_drive_reduced, .o_rtt_sel, .o_rtt_on,
      .o_additive_latency, .o_read_latency, .o_write_latency, .o_second_ext,
      .o_power_state, .o_int_read, .o_int_write, .o_read_data_due,
      .o_write_data_due, .o_pad);
   // clock
   initial begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end
   // counts dll reset pulses
   always @(posedge i_ref_clk)
      if (o_dll_reset === 1'b1)
         n_rst++;
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // field decode and register select
   task automatic t_fields;
      emr_ctl_inst.load(2'h1, 13'h0007);
      #1;
      `CHK({o_dll_enable, o_drive_reduced, o_rtt_sel}, 4'h5)
      emr_ctl_inst.load(2'h0, 13'h0040);
      emr_ctl_inst.load(2'h3, 13'h0040);
      emr_ctl_inst.load(2'h2, 13'h1445);
      #1;
      `CHK(o_rtt_sel, 2'h1)
      `CHK(o_second_ext, 13'h1445)
      emr_ctl_inst.load(2'h1, 13'h0040);
      #1;
      `CHK({o_dll_enable, o_drive_reduced, o_rtt_sel}, 4'hA)
      $display("fields done");
   endtask
   // termination pin and self refresh
   task automatic t_odt_sr;
      @(posedge i_ref_clk);
      i_odt <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      #1;
      `CHK(o_rtt_on, 1'b1)
      emr_ctl_inst.issue(3'h7, 1'b0, 2'h0, 13'h0000);
      #1;
      `CHK({o_power_state, o_rtt_on}, {pwr_power_down, 1'b1})
      emr_ctl_inst.issue(3'h7, 1'b1, 2'h0, 13'h0000);
      #1;
      `CHK(o_power_state, pwr_active)
      emr_ctl_inst.selfref(1'b1);
      repeat (2) @(posedge i_ref_clk);
      #1;
      `CHK({o_power_state, o_dll_enable, o_rtt_on}, 4'h8)
      emr_ctl_inst.selfref(1'b0);
      `CHK({o_dll_enable, n_rst[3:0]}, 5'h11)
      `CHK(o_power_state, pwr_active)
      @(posedge i_ref_clk);
      i_odt <= 1'b0;
      $display("odt and self refresh done");
   endtask
   // posted column commands for additive codes 0 to 5, CAS latency 3 and 4
   task automatic t_latency;
      int e;
      int cl;
      for (int a = 0; a < 6; a++) begin
         e = (a > 4) ? 0 : a;
         cl = 3 + a % 2;
         @(posedge i_ref_clk);
         i_cas_latency <= 3'(cl);
         emr_ctl_inst.load(2'h1, 13'(a << 3));
         #1;
         `CHK(o_additive_latency, 3'(a))
         `CHK(o_read_latency, 4'(e + cl))
         `CHK(o_write_latency, 4'(e + cl - 1))
         for (int w = 0; w < 2; w++) begin
            emr_ctl_inst.issue(w ? 3'h4 : 3'h5, 1'b1, 2'h0, 13'h0000);
            k = '{-1, -1};
            for (int j = 0; j < 12; j++) begin
               #1;
               if (k[0] < 0 && (w ? o_int_write : o_int_read) === 1'b1)
                  k[0] = j;
               if (k[1] < 0
                   && (w ? o_write_data_due : o_read_data_due) === 1'b1)
                  k[1] = j;
               @(posedge i_ref_clk);
            end
            `CHK(k[0], e)
            `CHK(k[1], e + cl - w)
         end
      end
      $display("latency done");
   endtask
   // strobe and output gating
   task automatic t_pads;
      logic [12:0] ad[4] = '{13'h0800, 13'h0C00, 13'h1800, 13'h0800};
      logic [7:0]  ex[4] = '{8'hDD, 8'hC4, 8'h00, 8'hD0};
      for (int i = 0; i < 4; i++) begin
         emr_ctl_inst.load(2'h1, ad[i]);
         @(posedge i_ref_clk);
         i_rd <= {3'h7, i != 3};
         repeat (2) @(posedge i_ref_clk);
         #1;
         `CHK(o_pad & (i ? 8'hD5 : 8'hFF), ex[i])
      end
      $display("pads done");
   endtask
   // mid-run reset clears stored settings, loads work after release
   task automatic t_reset;
      @(posedge i_ref_clk);
      i_arst_n <= 1'b0;
      @(posedge i_ref_clk);
      #1;
      `CHK({o_second_ext, o_dll_enable, o_rtt_sel, o_pad}, 24'h000400)
      @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      emr_ctl_inst.load(2'h2, 13'h1C25);
      #1;
      `CHK(o_second_ext, 13'h1C25)
      $display("reset done");
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      mismatches++;
      tally_and_finish;
   end
   // main sequence
   initial begin
      i_arst_n = 1'b0;
      i_odt = 1'b0;
      i_rd = '0;
      i_cas_latency = 3'h3;
      repeat (10) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      t_fields;
      t_odt_sr;
      t_latency;
      t_pads;
      t_reset;
      tally_and_finish;
   end
endmodule
